// *** core/ssc_defines.vh ***
// Constants for the secure session control frame interpreter.
// Assumes a 100 MHz system clock and a byte-wide host serial stream.
`ifndef SSC_DEFINES_VH
`define SSC_DEFINES_VH
// ==========================================
// Frame layout
`define START_DELIM 8'h7E
`define TYPE_REQ 8'h2E
`define TYPE_RESP 8'hAE
`define OFF_TYPE 16'h0003
`define OFF_DEST 16'h0004
`define OFF_OPTS 16'h000C
`define OFF_TMO_HI 16'h000D
`define OFF_TMO_LO 16'h000E
`define OFF_PW 16'h000F
`define LEN_MIN_LOGIN 16'h000C
`define PW_MAX 16'h0040
`define RESP_LEN 8'h03
`define CSUM_GOOD 8'hFF
`define BCAST_ADDR 64'h000000000000FFFF
`define TMO_MAX 16'h4650
`define OPT_LOGOUT 0
`define OPT_TERM 1
`define OPT_INTER 2
// ==========================================
// Status codes
`define ST_OK 8'h00
`define ST_NO_SESSION 8'h01
`define ST_AUTH_FAIL 8'h02
`define ST_INVALID 8'h0A
// ==========================================
// Timing
`define CLK_PERIOD_NS 10
`define HALF_SEC_NS 500000000
// ==========================================
// Register map (byte addresses)
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_INT_STAT 8'h08
`define REG_INT_MASK 8'h0C
`define REG_REMAIN 8'h10
`define REG_DEST_LO 8'h14
`define REG_DEST_HI 8'h18
`define CTRL_RESET 32'h00000001
`define EV_RESP 0
`define EV_DROP 1
`define EV_OPEN 2
`define EV_END 3
`define EV_W 4
`endif

// *** core/half_tick_gen.v ***
// Half-second tick generator.
// Assumes one free-running system clock; the tick is a one-cycle pulse.
`include "ssc_defines.vh"
`default_nettype none
module half_tick_gen #(
  parameter PERIOD = `HALF_SEC_NS / `CLK_PERIOD_NS
) (
  input wire sys_clk,
  input wire rst,
  output reg tick
);
  reg [31:0] cnt;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt <= 32'h00000000;
      tick <= 1'b0;
    end else if (cnt == PERIOD - 1) begin
      cnt <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 32'h00000001;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** core/resp_sender.v ***
// Serialiser for the secure session response frame.
// Assumes start arrives only while busy is low; tx follows valid/ready.
`include "ssc_defines.vh"
`default_nettype none
module resp_sender (
  input wire sys_clk,
  input wire rst,
  input wire start,
  input wire [7:0] opts,
  input wire [7:0] status,
  output reg [7:0] tx_data,
  output reg tx_valid,
  input wire tx_ready,
  output wire busy
);
  reg [2:0] pos;
  reg [7:0] o;
  reg [7:0] s;
  reg [7:0] next_byte;
  wire [7:0] csum = `CSUM_GOOD - (`TYPE_RESP + o + s);

  assign busy = tx_valid;

  always @* begin
    case (pos)
      3'h0: next_byte = 8'h00;
      3'h1: next_byte = `RESP_LEN;
      3'h2: next_byte = `TYPE_RESP;
      3'h3: next_byte = o;
      3'h4: next_byte = s;
      default: next_byte = csum;
    endcase
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pos <= 3'h0;
      o <= 8'h00;
      s <= 8'h00;
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
    end else if (start && !tx_valid) begin
      o <= opts;
      s <= status;
      pos <= 3'h0;
      tx_data <= `START_DELIM;
      tx_valid <= 1'b1;
    end else if (tx_valid && tx_ready) begin
      // The checksum is loaded at position 5, so the frame ends once it is taken.
      if (pos == 3'h6) begin
        tx_valid <= 1'b0;
      end else begin
        tx_data <= next_byte;
        pos <= pos + 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** core/secure_session_control.v ***
// Secure session control frame interpreter with APB registers.
// Assumes the host byte stream and the authentication engine share sys_clk.
// How it works
// (R1) The 16-bit length after the delimiter counts the bytes between it and the checksum.
// (R2) Only a frame whose type byte at offset 3 is 0x2E is acted upon.
// (R3) Every accepted request gets a response frame of type 0xAE.
// (R4) The host puts the 64-bit target address in offsets 4 to 11.
// (R5) The broadcast address applies the action to all incoming sessions.
// (R6) A login aimed at the broadcast address is refused with status 0xA.
// (R7) Options bits 0 and 1 both clear start client authentication with the target.
// (R8) Options bit 0 set closes the client session with the target.
// (R9) A logout ignores the other option bits, the timeout and the password.
// (R10) Options bit 1 set with bit 0 clear ends one incoming session, or all when broadcast.
// (R11) Options bit 2 clear makes the session end when its timeout runs out.
// (R12) Options bit 2 set restarts the timeout on each secured transfer.
// (R13) A successful login opens a secure session with the target.
// (R14) The timeout at offset 13 counts half seconds up to 0x4650; zero never expires.
// (R15) The password from offset 15 holds at most 64 bytes and only a login uses it.
// (R16) The checksum plus the sum of bytes from offset 3 must give 0xFF.
// (R17) Options bits 3 to 7 are ignored.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`include "ssc_defines.vh"
`default_nettype none
module secure_session_control #(
  parameter HALF_SEC_CYCLES = `HALF_SEC_NS / `CLK_PERIOD_NS
) (
  input wire sys_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [7:0] rx_data,
  input wire rx_valid,
  output wire rx_ready,
  output wire [7:0] tx_data,
  output wire tx_valid,
  input wire tx_ready,
  output reg [7:0] pw_data,
  output reg pw_valid,
  output reg auth_start,
  input wire auth_done,
  input wire auth_ok,
  output reg [63:0] req_dest,
  output reg term_req,
  output reg term_all,
  input wire sec_traffic,
  output reg session_active,
  output wire irq
);
  // ==========================================
  // Parser state
  localparam S_IDLE = 3'h0;
  localparam S_LEN_H = 3'h1;
  localparam S_LEN_L = 3'h2;
  localparam S_BODY = 3'h3;
  localparam S_CSUM = 3'h4;
  localparam S_EXEC = 3'h5;
  localparam S_WAIT = 3'h6;
  localparam S_RESP = 3'h7;

  reg [2:0] state;
  reg [15:0] len;
  reg [15:0] idx;
  reg [7:0] sum;
  reg [7:0] ftype;
  reg [7:0] opts;
  reg [15:0] tmo;
  reg [7:0] status;
  reg resp_start;
  reg [63:0] client_dest;
  reg [15:0] tmo_cfg;
  reg [15:0] remain;
  reg inter_mode;
  reg yielding;
  reg [`EV_W-1:0] ev;
  reg [31:0] ctrl;
  reg [`EV_W-1:0] int_stat;
  reg [`EV_W-1:0] int_mask;

  wire enable = ctrl[0];
  wire tx_busy;
  wire half_tick;
  wire rx_fire = rx_valid && rx_ready;
  wire [15:0] off = idx + `OFF_TYPE;
  wire is_bcast = (req_dest == `BCAST_ADDR);
  wire is_login = !opts[`OPT_LOGOUT] && !opts[`OPT_TERM];

  // The parser stalls the host while a request is executed and until its answer is started.
  assign rx_ready = enable && (state <= S_CSUM);

  // ==========================================
  // Helpers
  half_tick_gen #(.PERIOD(HALF_SEC_CYCLES)) u_tick (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(half_tick)
  );

  // Opts and status stay put until the sender has latched them at its start.
  resp_sender u_resp (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(resp_start),
    .opts(opts),
    .status(status),
    .tx_data(tx_data),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready),
    .busy(tx_busy)
  );

  // ==========================================
  // Frame interpreter and client session
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      len <= 16'h0000;
      idx <= 16'h0000;
      sum <= 8'h00;
      ftype <= 8'h00;
      opts <= 8'h00;
      tmo <= 16'h0000;
      status <= `ST_OK;
      resp_start <= 1'b0;
      req_dest <= 64'h0;
      client_dest <= 64'h0;
      tmo_cfg <= 16'h0000;
      remain <= 16'h0000;
      inter_mode <= 1'b0;
      yielding <= 1'b0;
      session_active <= 1'b0;
      pw_data <= 8'h00;
      pw_valid <= 1'b0;
      auth_start <= 1'b0;
      term_req <= 1'b0;
      term_all <= 1'b0;
      ev <= {`EV_W{1'b0}};
    end else begin
      resp_start <= 1'b0;
      pw_valid <= 1'b0;
      auth_start <= 1'b0;
      term_req <= 1'b0;
      ev <= {`EV_W{1'b0}};
      if (resp_start) begin
        ev[`EV_RESP] <= 1'b1;
      end

      // Session lifetime; a zero timeout marks a session that never expires.
      // A reload beats a tick in the same cycle, so a busy link in interactive mode never expires.
      if (session_active && !yielding) begin // (R14)
        if (sec_traffic && inter_mode) begin
          remain <= tmo_cfg; // (R12)
        end else if (half_tick) begin
          if (remain <= 16'h0001) begin
            session_active <= 1'b0; // (R11)
            remain <= 16'h0000;
            ev[`EV_END] <= 1'b1;
          end else begin
            remain <= remain - 16'h0001;
          end
        end
      end

      case (state)
        S_IDLE: begin
          if (rx_fire && rx_data == `START_DELIM) begin
            state <= S_LEN_H;
          end
        end
        S_LEN_H: begin
          if (rx_fire) begin
            len[15:8] <= rx_data; // (R1)
            state <= S_LEN_L;
          end
        end
        S_LEN_L: begin
          if (rx_fire) begin
            len[7:0] <= rx_data;
            idx <= 16'h0000;
            sum <= 8'h00;
            opts <= 8'h00;
            tmo <= 16'h0000;
            if (len[15:8] == 8'h00 && rx_data == 8'h00) begin
              ev[`EV_DROP] <= 1'b1;
              state <= S_IDLE;
            end else begin
              state <= S_BODY;
            end
          end
        end
        S_BODY: begin
          if (rx_fire) begin
            sum <= sum + rx_data; // (R16)
            idx <= idx + 16'h0001;
            if (off == `OFF_TYPE) begin
              ftype <= rx_data;
            end else if (off < `OFF_OPTS) begin
              req_dest <= {req_dest[55:0], rx_data}; // (R4)
            end else if (off == `OFF_OPTS) begin
              opts <= rx_data;
            end else if (off == `OFF_TMO_HI) begin
              tmo[15:8] <= rx_data;
            end else if (off == `OFF_TMO_LO) begin
              tmo[7:0] <= rx_data;
            end else if (is_login) begin
              // Only a login hands the password bytes on to the authenticator.
              pw_data <= rx_data; // (R15)
              pw_valid <= 1'b1;
            end
            if (idx + 16'h0001 == len) begin // (R1)
              state <= S_CSUM;
            end
          end
        end
        S_CSUM: begin
          if (rx_fire) begin
            // Bad sums and foreign frame types are dropped without an answer.
            if (sum + rx_data == `CSUM_GOOD && ftype == `TYPE_REQ) begin // (R16) (R2)
              state <= S_EXEC;
            end else begin
              ev[`EV_DROP] <= 1'b1;
              state <= S_IDLE;
            end
          end
        end
        S_EXEC: begin
          // Bits 3 to 7 of the options never reach any decision here.
          if (len < `OFF_OPTS - 16'h0002) begin // (R17)
            status <= `ST_INVALID;
            state <= S_RESP;
          end else if (opts[`OPT_LOGOUT]) begin // (R8) (R9)
            if (session_active && client_dest == req_dest) begin
              session_active <= 1'b0;
              ev[`EV_END] <= 1'b1;
              status <= `ST_OK;
            end else begin
              status <= `ST_NO_SESSION;
            end
            state <= S_RESP;
          end else if (opts[`OPT_TERM]) begin // (R10)
            term_req <= 1'b1;
            term_all <= is_bcast; // (R5)
            status <= `ST_OK;
            state <= S_RESP;
          end else if (is_bcast) begin // (R6)
            status <= `ST_INVALID;
            state <= S_RESP;
          end else if (len < `LEN_MIN_LOGIN || len > `LEN_MIN_LOGIN + `PW_MAX || tmo > `TMO_MAX) begin // (R14) (R15)
            status <= `ST_INVALID;
            state <= S_RESP;
          end else begin
            auth_start <= 1'b1; // (R7)
            state <= S_WAIT;
          end
        end
        S_WAIT: begin
          // There is no timeout here: a silent authenticator stalls the parser.
          if (auth_done) begin
            if (auth_ok) begin
              session_active <= 1'b1; // (R13)
              client_dest <= req_dest;
              tmo_cfg <= tmo;
              remain <= tmo;
              yielding <= (tmo == 16'h0000); // (R14)
              inter_mode <= opts[`OPT_INTER]; // (R11) (R12)
              ev[`EV_OPEN] <= 1'b1;
              status <= `ST_OK;
            end else begin
              status <= `ST_AUTH_FAIL;
            end
            state <= S_RESP;
          end
        end
        default: begin
          if (!tx_busy && !resp_start) begin
            resp_start <= 1'b1; // (R3)
            state <= S_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================
  // APB slave
  wire wr = psel && penable && pwrite;
  wire mapped = (paddr == `REG_CTRL) || (paddr == `REG_STATUS) ||
    (paddr == `REG_INT_STAT) || (paddr == `REG_INT_MASK) ||
    (paddr == `REG_REMAIN) || (paddr == `REG_DEST_LO) ||
    (paddr == `REG_DEST_HI);

  // Every access completes in its first access cycle.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign irq = |(int_stat & int_mask);

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl <= `CTRL_RESET;
      int_stat <= {`EV_W{1'b0}};
      int_mask <= {`EV_W{1'b0}};
    end else begin
      if (wr && paddr == `REG_CTRL) begin
        ctrl <= {31'h00000000, pwdata[0]};
      end
      if (wr && paddr == `REG_INT_MASK) begin
        int_mask <= pwdata[`EV_W-1:0];
      end
      // A new event in the clearing cycle keeps its bit set.
      if (wr && paddr == `REG_INT_STAT) begin
        int_stat <= (int_stat & ~pwdata[`EV_W-1:0]) | ev;
      end else begin
        int_stat <= int_stat | ev;
      end
    end
  end

  always @* begin
    if (paddr == `REG_CTRL) begin
      prdata = ctrl;
    end else if (paddr == `REG_STATUS) begin
      prdata = {16'h0000, status, 1'b0, state, yielding, inter_mode, tx_busy, session_active};
    end else if (paddr == `REG_INT_STAT) begin
      prdata = {{(32-`EV_W){1'b0}}, int_stat};
    end else if (paddr == `REG_INT_MASK) begin
      prdata = {{(32-`EV_W){1'b0}}, int_mask};
    end else if (paddr == `REG_REMAIN) begin
      prdata = {16'h0000, remain};
    end else if (paddr == `REG_DEST_LO) begin
      prdata = client_dest[31:0];
    end else if (paddr == `REG_DEST_HI) begin
      prdata = client_dest[63:32];
    end else begin
      prdata = 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// *** tb/secure_session_control_asserts.sv ***
// Assertion checker for the session frame interpreter.
// Assumes it is bound to the top module and sees its ports only.
`default_nettype none
module ssc_checker #(parameter HALF_SEC_CYCLES = 20) (
  input wire sys_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire [7:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire [7:0] tx_data,
  input wire tx_valid,
  input wire tx_ready,
  input wire auth_start,
  input wire auth_done,
  input wire auth_ok,
  input wire [63:0] req_dest,
  input wire term_req,
  input wire session_active
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Properties.
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx byte changed before it was taken");
  a_tx_start: assert property ($rose(tx_valid) |-> tx_data == 8'h7E)
    else $error("response does not open with a delimiter");
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("apb access stalled");
  a_bad_addr: assert property (psel && penable && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h18))
    else $error("apb error flag wrong");
  a_bcast_login: assert property (auth_start |-> req_dest != 64'h000000000000FFFF)
    else $error("login started toward broadcast");
  a_term_pulse: assert property (term_req |=> !term_req)
    else $error("termination pulse too long");
  a_open_cause: assert property ($rose(session_active) |-> $past(auth_done & auth_ok) | $past(auth_done & auth_ok, 2))
    else $error("session opened without good login");
  a_fail_closed: assert property (!session_active && auth_done && !auth_ok |=> !session_active)
    else $error("session opened after failed login");
  c_login: cover property (auth_start ##[1:50] auth_done);
  c_term: cover property (term_req);
  c_end: cover property ($fell(session_active));
endmodule
`default_nettype wire

// *** tb/host_model.sv ***
// Host processor model: sends request frames byte by byte and takes responses.
// Assumes one clock shared with the interpreter; tasks start just after an edge.
`default_nettype none
module host_model (
  input wire logic sys_clk,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
  end
  // Password bytes of the last frame, in the order they were sent.
  logic [7:0] pw_q[$];
  // Random stalls make the sender hold each response byte now and then.
  always @(posedge sys_clk)
    tx_ready <= 1'($urandom_range(1));
  // ==========================================
  // Byte and frame senders.
  task automatic put(input logic [7:0] b);
    rx_data <= b;
    rx_valid <= 1'b1;
    @(posedge sys_clk);
    for (int n = 0; n < 3000 && !rx_ready; n++)
      @(posedge sys_clk);
    if (!rx_ready)
      secure_session_control_tb.must(1'b0);
  endtask
  task automatic frame(input logic [7:0] typ, input logic [63:0] dst, input logic [7:0] opt,
                       input logic [15:0] tmo, input int npw, input logic bad);
    logic [7:0] b[$];
    logic [7:0] s;
    b = {typ};
    for (int i = 7; i >= 0; i--)
      b.push_back(dst[i*8 +: 8]);
    b.push_back(opt);
    b.push_back(tmo[15:8]);
    b.push_back(tmo[7:0]);
    pw_q.delete();
    repeat (npw) begin
      b.push_back(8'h41 + 8'($urandom_range(25)));
      pw_q.push_back(b[$]);
    end
    s = 8'hFF;
    foreach (b[i]) s = s - b[i];
    put(8'h7E);
    put(8'h00);
    put(8'(b.size()));
    foreach (b[i]) put(b[i]);
    put(s ^ {7'h00, bad});
    rx_valid <= 1'b0;
    // A released line shows the inverse so a stale byte cannot pass.
    rx_data <= ~rx_data;
    @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// *** tb/secure_session_control_tb.sv ***
// Testbench: sends requests, plays the authentication engine, checks responses.
// Assumes the host model and checker are compiled before it.
`default_nettype none
module secure_session_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF_SEC_CYCLES = 20;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rx_valid, rx_ready, tx_valid, tx_ready, pw_valid, auth_start;
  logic term_req, term_all, session_active, irq;
  logic [7:0] rx_data, tx_data, pw_data;
  logic [63:0] req_dest;
  logic auth_done = 1'b0;
  logic auth_ok = 1'b0;
  logic sec_traffic = 1'b0;
  logic ok_next = 1'b1;
  logic term_want = 1'b0;
  logic [63:0] dest_want = 64'h0;
  logic [7:0] exp[$];
  int err_count = 0;
  int comparisons = 0;
  int pw_seen = 0;
  int pw_base = 0;
  int pw_want = 0;
  int term_seen = 0;
  int auth_cnt = 0;
  secure_session_control #(.HALF_SEC_CYCLES(HALF_SEC_CYCLES)) i_dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rx_data(rx_data),
    .rx_valid(rx_valid),
    .rx_ready(rx_ready),
    .tx_data(tx_data),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready),
    .pw_data(pw_data),
    .pw_valid(pw_valid),
    .auth_start(auth_start),
    .auth_done(auth_done),
    .auth_ok(auth_ok),
    .req_dest(req_dest),
    .term_req(term_req),
    .term_all(term_all),
    .sec_traffic(sec_traffic),
    .session_active(session_active),
    .irq(irq)
  );
  host_model i_host (
    .sys_clk(sys_clk),
    .rx_data(rx_data),
    .rx_valid(rx_valid),
    .rx_ready(rx_ready),
    .tx_ready(tx_ready)
  );
  initial forever #5 sys_clk = ~sys_clk;
  // ==========================================
  // Shared tasks.
  task automatic chk(input logic [63:0] got, input logic [63:0] want);
    comparisons++;
    if (got !== want) begin
      err_count++;
      $display("ERROR %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic give_verdict();
    if (err_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic must(input logic ok);
    chk(ok, 1'b1);
    if (ok !== 1'b1)
      give_verdict();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    for (int n = 0; n < 50 && !pready; n++)
      @(posedge sys_clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] want, input logic err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, want);
    chk(e, err);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk(e, 1'b0);
  endtask
  task automatic req(input logic [63:0] d, input logic [7:0] o, input logic [15:0] t, input int n,
                     input logic [7:0] st);
    dest_want = d;
    pw_want = n;
    pw_base = pw_seen;
    exp = {exp, 8'h7E, 8'h00, 8'h03, 8'hAE, o, st, 8'hFF - 8'hAE - o - st};
    i_host.frame(8'h2E, d, o, t, n, 1'b0);
    for (int k = 0; k < 2000 && exp.size() != 0; k++)
      @(posedge sys_clk);
    must(exp.size() == 0);
    repeat (3) @(posedge sys_clk);
  endtask
  // ==========================================
  // Authentication engine and output monitor.
  always @(posedge sys_clk) begin
    auth_done <= (auth_cnt == 1);
    auth_ok <= ok_next;
    if (auth_cnt != 0)
      auth_cnt <= auth_cnt - 1;
    if (pw_valid) begin
      pw_seen++;
      chk(i_host.pw_q.size() != 0, 1'b1);
      if (i_host.pw_q.size() != 0)
        chk(pw_data, i_host.pw_q.pop_front());
    end
    if (term_req) begin
      chk(term_all, term_want);
      term_seen++;
    end
    if (auth_start) begin
      chk(req_dest, dest_want);
      chk(pw_seen - pw_base, pw_want);
      auth_cnt <= 5;
    end
    if (tx_valid && tx_ready) begin
      chk(exp.size() != 0, 1'b1);
      if (exp.size() != 0)
        chk(tx_data, exp.pop_front());
    end
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    must(1'b0);
  end
  // ==========================================
  // Main sequence.
  initial begin
    logic [63:0] d;
    void'($urandom(45));
    d = {$urandom, $urandom};
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(8'h0C, 32'h0, 1'b0);
    rd(8'h00, 32'h1, 1'b0);
    wr(8'h00, 32'h0);
    chk(rx_ready, 1'b0);
    wr(8'h00, 32'h1);
    rd(8'h44, 32'h0, 1'b1);
    wr(8'h0C, 32'hF);
    req(d, 8'h00, 16'h0004, 8, 8'h00);
    must(session_active);
    rd(8'h14, d[31:0], 1'b0);
    rd(8'h18, d[63:32], 1'b0);
    rd(8'h08, 32'h5, 1'b0);
    chk(irq, 1'b1);
    wr(8'h08, 32'hF);
    chk(irq, 1'b0);
    // Traffic must not stretch a fixed session.
    for (int n = 0; n < 90 && session_active; n++) begin
      sec_traffic <= n[0];
      @(posedge sys_clk);
    end
    sec_traffic <= 1'b0;
    must(!session_active);
    req(d ^ 64'h1, 8'h04, 16'h0002, 3, 8'h00);
    for (int n = 0; n < 150; n++) begin
      sec_traffic <= (n % 10 == 0);
      @(posedge sys_clk);
    end
    sec_traffic <= 1'b0;
    must(session_active);
    repeat (60) @(posedge sys_clk);
    must(!session_active);
    req(d, 8'h08, 16'h0000, 1, 8'h00);
    repeat (100) @(posedge sys_clk);
    must(session_active);
    req(d, 8'h0D, 16'h4651, 2, 8'h00);
    must(!session_active);
    req(d, 8'h01, 16'h0000, 0, 8'h01);
    req(64'h000000000000FFFF, 8'h00, 16'h0001, 0, 8'h0A);
    req(d, 8'h00, 16'h4651, 0, 8'h0A);
    ok_next = 1'b0;
    req(d, 8'h00, 16'h0001, 0, 8'h02);
    must(!session_active);
    term_want = 1'b1;
    req(64'h000000000000FFFF, 8'h02, 16'h0000, 0, 8'h00);
    term_want = 1'b0;
    req(d, 8'h06, 16'h0000, 0, 8'h00);
    wr(8'h08, 32'hF);
    i_host.frame(8'h2D, d, 8'h00, 16'h0001, 0, 1'b0);
    i_host.frame(8'h2E, d, 8'h00, 16'h0001, 0, 1'b1);
    repeat (5) @(posedge sys_clk);
    rd(8'h08, 32'h2, 1'b0);
    chk(irq, 1'b1);
    wr(8'h08, 32'h2);
    chk(irq, 1'b0);
    chk(term_seen, 2);
    give_verdict();
  end
endmodule
bind secure_session_control ssc_checker #(.HALF_SEC_CYCLES(HALF_SEC_CYCLES)) i_chk (
  .sys_clk(sys_clk),
  .rst(rst),
  .psel(psel),
  .penable(penable),
  .paddr(paddr),
  .pready(pready),
  .pslverr(pslverr),
  .tx_data(tx_data),
  .tx_valid(tx_valid),
  .tx_ready(tx_ready),
  .auth_start(auth_start),
  .auth_done(auth_done),
  .auth_ok(auth_ok),
  .req_dest(req_dest),
  .term_req(term_req),
  .session_active(session_active)
);
`default_nettype wire
